// ==== cmd_port_pkg.sv ====
// shared constants, types and decode functions of the command and status port
`default_nettype none
package cmd_port_pkg;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] DUMMY_CMD = 8'hFF;
  localparam logic [7:0] PKT_WRITE_CMD = 8'h10;
  localparam logic [7:0] PKT_READ_CMD = 8'h30;
  localparam logic [7:0] SEQ_WRITE_BASE = 8'h18;
  localparam logic [7:0] SEQ_READ_BASE = 8'h38;
  localparam logic [7:0] RANDOM_MEMORY_WRITE_CMD = 8'h08;
  localparam logic [7:0] RANDOM_MEMORY_READ_CMD = 8'h28;
  localparam logic [7:0] FIRMWARE_STORE_WRITE_CMD = 8'h1E;
  localparam logic [7:0] GO_SLEEP_CMD = 8'hB1;
  localparam logic [7:0] GO_IDLE_CMD = 8'hB2;
  localparam logic [7:0] GO_LINK_PREPARED_CMD = 8'hB3;
  localparam logic [7:0] GO_RECEIVE_CMD = 8'hB4;
  localparam logic [7:0] GO_TRANSMIT_CMD = 8'hB5;
  localparam logic [7:0] GO_METERING_CMD = 8'hB6;
  localparam logic [7:0] CHANNEL_ASSESS_CMD = 8'hB7;
  localparam logic [7:0] FIRMWARE_COUNTER_RESET_CMD = 8'hC7;
  localparam logic [7:0] DEVICE_RESET_CMD = 8'hC8;
  // base part of a code whose low bits carry address[10:8]
  localparam logic [7:0] BASE_MASK = 8'hF8;
  // ---------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int ADDR_HI_W = 3;
  localparam logic [2:0] ADDR_HI_ZERO = 3'h0;
  localparam logic [7:0] ADDR_LO_ZERO = 8'h00;
  // ---------------------------------------------------------------
  // status word layout and state codes
  // ---------------------------------------------------------------
  localparam int ST_PORT_READY = 7;
  localparam int ST_IRQ = 6;
  localparam int ST_CONTROLLER_READY_FLAG = 5;
  localparam int ST_CCA = 4;
  localparam logic [3:0] CODE_RESERVED = 4'h0;
  localparam logic [3:0] CODE_IDLE = 4'h1;
  localparam logic [3:0] CODE_METERING = 4'h2;
  localparam logic [3:0] CODE_LINK_PREPARED = 4'h3;
  localparam logic [3:0] CODE_RECEIVE = 4'h4;
  localparam logic [3:0] CODE_TRANSMIT = 4'h5;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ---------------------------------------------------------------
  // frame counting on the link side
  // ---------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [1:0] IDX_CMD = 2'h0;
  localparam logic [1:0] IDX_PARAM = 2'h1;
  localparam logic [1:0] IDX_MORE = 2'h2;
  // synchroniser lanes and their idle values
  localparam int SY_W = 4;
  localparam int SY_CS = 3;
  localparam int SY_GO = 2;
  localparam int SY_IRQ_A = 1;
  localparam int SY_IRQ_B = 0;
  localparam logic [3:0] SY_RESET = 4'h8;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP, ST_IDLE, ST_METERING, ST_LINK_PREPARED, ST_RECEIVE, ST_TRANSMIT
  } ctl_state_e;
  typedef enum logic [2:0] {
    MEM_NONE, MEM_PKT_WR, MEM_PKT_RD, MEM_SEQ_WR, MEM_SEQ_RD,
    MEM_RANDOM_WR, MEM_RANDOM_RD, MEM_FW_WR
  } mem_kind_e;
  // sort a command byte into its memory-access kind
  function automatic mem_kind_e mem_kind(input logic [7:0] cmd);
    mem_kind = MEM_NONE;
    if (cmd == FIRMWARE_STORE_WRITE_CMD) mem_kind = MEM_FW_WR;
    else if (cmd == PKT_WRITE_CMD) mem_kind = MEM_PKT_WR;
    else if (cmd == PKT_READ_CMD) mem_kind = MEM_PKT_RD;
    else if ((cmd & BASE_MASK) == SEQ_WRITE_BASE) mem_kind = MEM_SEQ_WR;
    else if ((cmd & BASE_MASK) == SEQ_READ_BASE) mem_kind = MEM_SEQ_RD;
    else if ((cmd & BASE_MASK) == RANDOM_MEMORY_WRITE_CMD) mem_kind = MEM_RANDOM_WR;
    else if ((cmd & BASE_MASK) == RANDOM_MEMORY_READ_CMD) mem_kind = MEM_RANDOM_RD;
  endfunction
  // true for any memory-access command
  function automatic logic is_mem(input logic [7:0] cmd);
    is_mem = (mem_kind(cmd) != MEM_NONE);
  endfunction
endpackage
`default_nettype wire

// ==== level_sync.sv ====
// two-flop synchroniser for a group of independent levels
`default_nettype none
module level_sync (
  // system clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // asynchronous levels in, synchronised levels out
  input wire logic [cmd_port_pkg::SY_W-1:0] async_in,
  output logic [cmd_port_pkg::SY_W-1:0] sync_out
);
  typedef struct packed {
    logic [cmd_port_pkg::SY_W-1:0] meta;  // first stage, read only by second
    logic [cmd_port_pkg::SY_W-1:0] stable;  // second stage
  } sync_s;
  sync_s sy_r, sy_nxt;
  // shift each lane one stage on
  always_comb begin
    sy_nxt = sy_r;
    sy_nxt.meta = async_in;
    sy_nxt.stable = sy_r.meta;
  end
  // both stages reset to the idle levels
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sy_r <= {cmd_port_pkg::SY_RESET, cmd_port_pkg::SY_RESET};
    end else begin
      sy_r <= sy_nxt;
    end
  end
  assign sync_out = sy_r.stable;
endmodule
`default_nettype wire

// ==== frame_shifter.sv ====
// link-side byte shifter, clocked by the host's serial clock
`default_nettype none
module frame_shifter (
  // link pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // status word, held still by the system side during a frame
  input wire logic [7:0] status_in,
  // command capture toward the system side
  output logic [7:0] cmd_byte_out,
  output logic cmd_full_out,
  output logic mem_go_out
);
  // frame state, cleared whenever chip select is high
  typedef struct packed {
    logic [2:0] bit_cnt;  // bits taken in current byte
    logic [1:0] byte_idx;  // command, first parameter, later
    logic [6:0] shift;  // bits so far, msb first
  } frame_s;
  frame_s fr_r, fr_nxt;
  logic [7:0] cmd_r, cmd_nxt;  // last command byte, kept past frame end
  logic full_r, full_nxt;  // command byte complete in last frame
  logic go_r, go_nxt;  // launch level, kept past frame end for the system clock
  logic [7:0] rx_byte;  // byte as it completes
  logic [7:0] out_r;  // outgoing status bits
  logic shown_r;  // a falling edge has passed in this frame
  logic [7:0] out_base;  // word to shift from
  // next frame state on each rising edge
  always_comb begin
    fr_nxt = fr_r;
    cmd_nxt = cmd_r;
    full_nxt = full_r;
    go_nxt = go_r;
    rx_byte = {fr_r.shift, mosi_in};  // see RQ23
    fr_nxt.shift = rx_byte[6:0];
    fr_nxt.bit_cnt = fr_r.bit_cnt + cmd_port_pkg::BIT_STEP;
    // first edge of a frame forgets the previous command and launch
    if (fr_r.bit_cnt == cmd_port_pkg::BIT_FIRST && fr_r.byte_idx == cmd_port_pkg::IDX_CMD) begin
      full_nxt = 1'b0;
      go_nxt = 1'b0;
    end
    // msb edge of first parameter launches memory access
    if (fr_r.bit_cnt == cmd_port_pkg::BIT_FIRST && fr_r.byte_idx == cmd_port_pkg::IDX_PARAM
        && cmd_port_pkg::is_mem(cmd_r)) begin
      go_nxt = 1'b1;  // see RQ4
    end
    // byte boundary
    if (fr_r.bit_cnt == cmd_port_pkg::BIT_LAST) begin
      if (fr_r.byte_idx == cmd_port_pkg::IDX_CMD) begin
        cmd_nxt = rx_byte;  // see RQ1
        full_nxt = 1'b1;
        // a dummy leaves the command slot open
        if (rx_byte != cmd_port_pkg::DUMMY_CMD) begin
          fr_nxt.byte_idx = cmd_port_pkg::IDX_PARAM;  // see RQ5
        end
      end else begin
        fr_nxt.byte_idx = cmd_port_pkg::IDX_MORE;  // see RQ5
      end
    end
  end
  // frame state ends with the frame's own chip select
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end
  // command capture survives chip select rising
  always_ff @(posedge sclk_in) begin
    cmd_r <= cmd_nxt;
    full_r <= full_nxt;
    go_r <= go_nxt;
  end
  // status bits change on falling edges, a new word each byte
  assign out_base = shown_r ? out_r : status_in;
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_r <= '0;
      shown_r <= 1'b0;
    end else begin
      shown_r <= 1'b1;
      if (fr_r.bit_cnt == cmd_port_pkg::BIT_FIRST) begin
        out_r <= status_in;  // see RQ8
      end else begin
        out_r <= {out_base[6:0], 1'b0};  // see RQ23
      end
    end
  end
  // top status bit shows as soon as chip select falls
  assign miso_out = cs_n_in ? 1'b0 : (shown_r ? out_r[7] : status_in[7]);  // see RQ23
  assign miso_oe_out = ~cs_n_in;
  assign cmd_byte_out = cmd_r;
  assign cmd_full_out = full_r;
  assign mem_go_out = go_r;
endmodule
`default_nettype wire

// ==== radio_command_status_port.sv ====
// command decoder and status word generator of the radio's serial slave port
//
// Function
// RQ1: every instruction is one command byte
// RQ2: memory commands served regardless of controller state
// RQ3: host lowers chip select, then shifts command
// RQ4: controller commands at select rise, memory at parameter
// RQ5: one command per select low, dummies excepted
// RQ6: host waits for ready flag before commands
// RQ7: dummy byte polls status, changes nothing
// RQ8: one status byte returned per byte in
// RQ9: state code changes only when transition completes
// RQ10: status bit 7 shows port ready
// RQ11: status bit 6 shows either interrupt pin
// RQ12: status bit 5 shows controller ready
// RQ13: status bit 4 shows channel assessment result
// RQ14: status bits 3..0 carry controller state code
// RQ15: 0x10 writes packet memory from transmit base
// RQ16: 0x30 reads packet memory from receive base
// RQ17: sequential codes 0x18, 0x38 plus address high
// RQ18: random codes 0x08, 0x28 plus address high
// RQ19: 0x1E writes firmware store
// RQ20: 0xB1..0xB6 request the six state transitions
// RQ21: 0xB7 starts clear channel assessment
// RQ22: 0xC7 resets firmware counter, 0xC8 device
// RQ23: sample rising, drive falling, msb first
// RQ24: host sends address low byte after sequential
// RQ25: host issues memory commands only when ready
// RQ26: unknown codes ignored, status still returned
`default_nettype none
module radio_command_status_port (
  // system clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,

  // serial link from the host
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,

  // interrupt pins, seen for the status word
  input wire logic interrupt_pin_a_in,
  input wire logic interrupt_pin_b_in,

  // status sources on the system clock
  input wire logic port_ready_in,
  input wire logic cca_result_in,
  input wire logic rc_done_in,

  // packet base pointers
  input wire logic [7:0] tx_base_in,
  input wire logic [7:0] rx_base_in,

  // radio controller strobes
  output logic rc_request_out,
  output cmd_port_pkg::ctl_state_e rc_target_out,
  output logic channel_assess_start_out,
  output logic firmware_counter_reset_out,
  output logic device_reset_out,

  // controller view
  output logic controller_ready_flag_out,
  output logic [3:0] controller_state_code_out,
  output logic [7:0] status_word_out,

  // memory access launch
  output logic mem_start_out,
  output cmd_port_pkg::mem_kind_e mem_kind_out,
  output logic [cmd_port_pkg::ADDR_W-1:0] mem_addr_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_prev;  // synced chip select, one cycle late
    logic go_prev;  // synced memory launch, one cycle late
    logic [7:0] status_hold;  // word the link shifts out
    cmd_port_pkg::ctl_state_e state;  // completed controller state
    cmd_port_pkg::ctl_state_e target;  // state being entered
    logic busy;  // transition or assessment running
    logic rc_req;  // transition request pulse
    logic cca_start;  // assessment start pulse
    logic pc_reset;  // firmware counter reset pulse
    logic dev_reset;  // whole device reset pulse
    logic mem_start;  // memory access launch pulse
    cmd_port_pkg::mem_kind_e mem_kind;  // kind of last launch
    logic [cmd_port_pkg::ADDR_W-1:0] mem_addr;  // start address of launch
  } port_s;
  port_s cur_r, cur_nxt;

  // ---------------------------------------------------------------
  // crossing and link side
  // ---------------------------------------------------------------
  logic [cmd_port_pkg::SY_W-1:0] sy;  // synchronised levels
  logic [7:0] cmd_byte;  // command byte, still while link idle
  logic cmd_full;  // command byte complete
  logic mem_go;  // link launched a memory command

  // chip select, launch and interrupt pins pass two flops
  level_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .async_in({cs_n_in, mem_go, interrupt_pin_a_in, interrupt_pin_b_in}),
    .sync_out(sy)
  );

  // byte shifting on the host's clock
  frame_shifter u_shift (
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .miso_out(miso_out),
    .miso_oe_out(miso_oe_out),
    .status_in(cur_r.status_hold),
    .cmd_byte_out(cmd_byte),
    .cmd_full_out(cmd_full),
    .mem_go_out(mem_go)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // state code shown in the status word
  function automatic logic [3:0] code_of(input cmd_port_pkg::ctl_state_e st);
    case (st)
      cmd_port_pkg::ST_IDLE: code_of = cmd_port_pkg::CODE_IDLE;
      cmd_port_pkg::ST_METERING: code_of = cmd_port_pkg::CODE_METERING;
      cmd_port_pkg::ST_LINK_PREPARED: code_of = cmd_port_pkg::CODE_LINK_PREPARED;
      cmd_port_pkg::ST_RECEIVE: code_of = cmd_port_pkg::CODE_RECEIVE;
      cmd_port_pkg::ST_TRANSMIT: code_of = cmd_port_pkg::CODE_TRANSMIT;
      // sleep has no code of its own
      default: code_of = cmd_port_pkg::CODE_RESERVED;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // decode and status
  // ---------------------------------------------------------------
  logic cs_rise;  // frame just ended
  logic go_rise;  // memory command just launched
  logic [7:0] live;  // status as it stands now
  logic req_valid;  // command asks for a transition
  cmd_port_pkg::ctl_state_e req_target;  // state it asks for
  cmd_port_pkg::mem_kind_e kind;  // kind of captured command

  // next state of the whole port
  always_comb begin
    cur_nxt = cur_r;
    req_valid = 1'b0;
    req_target = cur_r.state;
    kind = cmd_port_pkg::mem_kind(cmd_byte);

    // strobes last one cycle
    cur_nxt.rc_req = 1'b0;
    cur_nxt.cca_start = 1'b0;
    cur_nxt.pc_reset = 1'b0;
    cur_nxt.dev_reset = 1'b0;
    cur_nxt.mem_start = 1'b0;

    // edges of the synchronised levels
    cs_rise = sy[cmd_port_pkg::SY_CS] & ~cur_r.cs_prev;
    go_rise = sy[cmd_port_pkg::SY_GO] & ~cur_r.go_prev;
    cur_nxt.cs_prev = sy[cmd_port_pkg::SY_CS];
    cur_nxt.go_prev = sy[cmd_port_pkg::SY_GO];

    // assemble the live status word
    live = cmd_port_pkg::STATUS_RESET;
    live[cmd_port_pkg::ST_PORT_READY] = port_ready_in;  // see RQ10
    live[cmd_port_pkg::ST_IRQ] = sy[cmd_port_pkg::SY_IRQ_A] | sy[cmd_port_pkg::SY_IRQ_B];  // see RQ11
    live[cmd_port_pkg::ST_CONTROLLER_READY_FLAG] = ~cur_r.busy;  // see RQ12
    live[cmd_port_pkg::ST_CCA] = cca_result_in;  // see RQ13
    live[3:0] = code_of(cur_r.state);  // see RQ14

    // word only moves while the link is idle, so it is still in a frame
    if (sy[cmd_port_pkg::SY_CS]) begin
      cur_nxt.status_hold = live;  // see RQ8
    end

    // completed transition updates the state code
    if (rc_done_in && cur_r.busy) begin
      cur_nxt.busy = 1'b0;
      cur_nxt.state = cur_r.target;  // see RQ9
    end

    // memory access launch, independent of controller state
    if (go_rise) begin
      cur_nxt.mem_start = 1'b1;  // see RQ2
      cur_nxt.mem_kind = kind;

      case (kind)
        // packet write from transmit base
        cmd_port_pkg::MEM_PKT_WR: begin
          cur_nxt.mem_addr = {cmd_port_pkg::ADDR_HI_ZERO, tx_base_in};  // see RQ15
        end

        // packet read from receive base
        cmd_port_pkg::MEM_PKT_RD: begin
          cur_nxt.mem_addr = {cmd_port_pkg::ADDR_HI_ZERO, rx_base_in};  // see RQ16
        end

        // sequential access, high bits from the code
        cmd_port_pkg::MEM_SEQ_WR, cmd_port_pkg::MEM_SEQ_RD: begin
          cur_nxt.mem_addr = {cmd_byte[cmd_port_pkg::ADDR_HI_W-1:0],
                              cmd_port_pkg::ADDR_LO_ZERO};  // see RQ17
        end

        // random block access, high bits from the code
        cmd_port_pkg::MEM_RANDOM_WR, cmd_port_pkg::MEM_RANDOM_RD: begin
          cur_nxt.mem_addr = {cmd_byte[cmd_port_pkg::ADDR_HI_W-1:0],
                              cmd_port_pkg::ADDR_LO_ZERO};  // see RQ18
        end

        // firmware store starts at its origin
        cmd_port_pkg::MEM_FW_WR: begin
          cur_nxt.mem_addr = '0;  // see RQ19
        end

        // not reachable through the link
        default: begin
          cur_nxt.mem_addr = cur_r.mem_addr;
        end
      endcase
    end

    // controller commands take effect as the frame ends
    if (cs_rise && cmd_full) begin
      case (cmd_byte)
        // state transition requests
        cmd_port_pkg::GO_SLEEP_CMD: begin
          req_valid = 1'b1;  // see RQ20
          req_target = cmd_port_pkg::ST_SLEEP;
        end

        cmd_port_pkg::GO_IDLE_CMD: begin
          req_valid = 1'b1;  // see RQ20
          req_target = cmd_port_pkg::ST_IDLE;
        end

        cmd_port_pkg::GO_LINK_PREPARED_CMD: begin
          req_valid = 1'b1;  // see RQ20
          req_target = cmd_port_pkg::ST_LINK_PREPARED;
        end

        cmd_port_pkg::GO_RECEIVE_CMD: begin
          req_valid = 1'b1;  // see RQ20
          req_target = cmd_port_pkg::ST_RECEIVE;
        end

        cmd_port_pkg::GO_TRANSMIT_CMD: begin
          req_valid = 1'b1;  // see RQ20
          req_target = cmd_port_pkg::ST_TRANSMIT;
        end

        cmd_port_pkg::GO_METERING_CMD: begin
          req_valid = 1'b1;  // see RQ20
          req_target = cmd_port_pkg::ST_METERING;
        end

        // assessment keeps the state, holds the controller busy
        cmd_port_pkg::CHANNEL_ASSESS_CMD: begin
          if (!cur_r.busy) begin
            cur_nxt.cca_start = 1'b1;  // see RQ21
            cur_nxt.busy = 1'b1;
            cur_nxt.target = cur_r.state;
          end
        end

        // firmware counter back to start
        cmd_port_pkg::FIRMWARE_COUNTER_RESET_CMD: begin
          cur_nxt.pc_reset = 1'b1;  // see RQ22
        end

        // whole device reset ends in sleep, overriding any transition
        cmd_port_pkg::DEVICE_RESET_CMD: begin
          cur_nxt.dev_reset = 1'b1;  // see RQ22
          cur_nxt.busy = 1'b0;
          cur_nxt.state = cmd_port_pkg::ST_SLEEP;
          cur_nxt.target = cmd_port_pkg::ST_SLEEP;
        end

        // dummy, memory and unknown codes change nothing here
        default: begin
          req_valid = 1'b0;  // see RQ7, RQ26
        end
      endcase
    end

    // a request while busy is dropped, the old state code stays
    if (req_valid && !cur_r.busy) begin
      cur_nxt.rc_req = 1'b1;
      cur_nxt.busy = 1'b1;
      cur_nxt.target = req_target;  // see RQ9
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // all port state, reset to sleep with idle link
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      // link edge history at idle levels
      cur_r.cs_prev <= 1'b1;
      cur_r.go_prev <= 1'b0;
      // status and controller state
      cur_r.status_hold <= cmd_port_pkg::STATUS_RESET;
      cur_r.state <= cmd_port_pkg::ST_SLEEP;
      cur_r.target <= cmd_port_pkg::ST_SLEEP;
      cur_r.busy <= 1'b0;
      // strobes idle
      cur_r.rc_req <= 1'b0;
      cur_r.cca_start <= 1'b0;
      cur_r.pc_reset <= 1'b0;
      cur_r.dev_reset <= 1'b0;
      cur_r.mem_start <= 1'b0;
      // no launch yet
      cur_r.mem_kind <= cmd_port_pkg::MEM_NONE;
      cur_r.mem_addr <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from state flops
  // ---------------------------------------------------------------
  assign rc_request_out = cur_r.rc_req;
  assign rc_target_out = cur_r.target;
  assign channel_assess_start_out = cur_r.cca_start;
  assign firmware_counter_reset_out = cur_r.pc_reset;
  assign device_reset_out = cur_r.dev_reset;

  // controller view
  assign controller_ready_flag_out = ~cur_r.busy;
  assign controller_state_code_out = cur_r.status_hold[3:0];
  assign status_word_out = cur_r.status_hold;

  // memory launch
  assign mem_start_out = cur_r.mem_start;
  assign mem_kind_out = cur_r.mem_kind;
  assign mem_addr_out = cur_r.mem_addr;
endmodule
`default_nettype wire

// ==== radio_command_status_port_sva.sv ====
// assertions on the ports of the command and status port
`default_nettype none
module radio_command_status_port_sva (
  // clock, reset and watched ports
  input wire logic clk_sys_in, srst_in, cs_n_in, miso_out, miso_oe_out,
  input wire logic interrupt_pin_a_in, interrupt_pin_b_in, port_ready_in, cca_result_in,
  input wire logic rc_done_in, rc_request_out, device_reset_out, mem_start_out,
  input wire logic controller_ready_flag_out, channel_assess_start_out,
  input wire logic [3:0] controller_state_code_out,
  input wire logic [7:0] status_word_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  oe_follows_cs_a: assert property (miso_oe_out == !cs_n_in)
    else $error("miso enable not tied to select");
  miso_idle_a: assert property (cs_n_in |-> !miso_out) else $error("miso not low");
  code_copy_a: assert property (controller_state_code_out == status_word_out[3:0])
    else $error("state code differs from status");
  ready_drop_a: assert property (rc_request_out |=> !controller_ready_flag_out)
    else $error("ready kept after request");
  ready_back_a: assert property ($rose(controller_ready_flag_out) |->
    $past(rc_done_in) || device_reset_out || $past(device_reset_out)) else $error("ready early");
  busy_refuse_a: assert property (rc_request_out |-> $past(controller_ready_flag_out))
    else $error("request while busy");
  req_at_cs_a: assert property (rc_request_out |-> $past(cs_n_in, 2))
    else $error("request before select rise");
  frame_frozen_a: assert property ((!cs_n_in)[*5] |-> $stable(status_word_out))
    else $error("status moved in frame");
  code_hold_a: assert property (!controller_ready_flag_out && !device_reset_out |=>
    $stable(controller_state_code_out)) else $error("code moved while busy");
  status_live_a: assert property ((cs_n_in && $stable({port_ready_in, cca_result_in,
    interrupt_pin_a_in, interrupt_pin_b_in}))[*6] |-> {status_word_out[7:6], status_word_out[4]}
    == {port_ready_in, interrupt_pin_a_in | interrupt_pin_b_in, cca_result_in})
    else $error("status flags wrong");
  cover property (rc_request_out);
  cover property (mem_start_out);
  cover property (channel_assess_start_out);
endmodule
bind radio_command_status_port radio_command_status_port_sva u_sva (.*);
`default_nettype wire

// ==== spi_host_model.sv ====
// host serial master model, link clock period 30 ns, idle low
`default_nettype none
module spi_host_model (
  output logic sclk_out, cs_n_out, mosi_out,
  input wire logic miso_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one frame of n bits msb first; first returned byte kept
  task automatic frame(input logic [15:0] d, input int n, output logic [7:0] st);
    cs_n_out = 1'b0;
    #150;
    for (int i = 0; i < n; i++) begin
      mosi_out = d[15-i];
      #15 sclk_out = 1'b1;
      if (i < 8) st[7-i] = miso_in;
      #15 sclk_out = 1'b0;
    end
    #15 cs_n_out = 1'b1;
    mosi_out = !mosi_out;
    #250;
  endtask
endmodule
`default_nettype wire

// ==== tb_radio_command_status_port.sv ====
// self-checking bench of the command and status port
`default_nettype none
module tb_radio_command_status_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0, srst_in = 1, sclk_in, cs_n_in, mosi_in, miso_out, miso_oe_out;
  logic interrupt_pin_a_in = 0, interrupt_pin_b_in = 0, port_ready_in = 0, cca_result_in = 0;
  logic rc_done_in = 0, rc_request_out, channel_assess_start_out, firmware_counter_reset_out;
  logic device_reset_out, controller_ready_flag_out, mem_start_out;
  logic [7:0] tx_base_in = 8'h00, rx_base_in = 8'h00, status_word_out, st, cmd, tv, rv;
  logic [3:0] controller_state_code_out;
  logic [10:0] mem_addr_out, a;
  cmd_port_pkg::ctl_state_e rc_target_out;
  cmd_port_pkg::mem_kind_e mem_kind_out;
  logic [2:0] tgt [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h2};
  logic [7:0] mem_tab [7] = '{8'h10, 8'h30, 8'h18, 8'h38, 8'h08, 8'h28, 8'h1e};
  logic [21:0] exp_q[$], obs;
  int mismatches = 0, check_count = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  spi_host_model u_host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .mosi_out(mosi_in),
    .miso_in(miso_out));
  radio_command_status_port u_dut (.*);
  task automatic chk(string nm, logic [21:0] e, logic [21:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // watcher: each strobe takes the oldest note
  always @(posedge clk_sys_in) begin
    obs = {rc_request_out, channel_assess_start_out, firmware_counter_reset_out,
      device_reset_out, mem_start_out, rc_request_out ? 3'(rc_target_out) : 3'h0,
      mem_start_out ? {3'(mem_kind_out), mem_addr_out} : 14'h0000};
    if (|obs[21:17]) chk("strobe", exp_q.size() ? exp_q.pop_front() : 22'h00_0000, obs);
  end
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // dummy poll with fresh random flags
  task automatic poll(logic [3:0] c, logic rdy);
    @(posedge clk_sys_in);
    {port_ready_in, cca_result_in, interrupt_pin_a_in, interrupt_pin_b_in} <= 4'($urandom);
    repeat (6) @(posedge clk_sys_in);
    u_host.frame(16'hffff, 8, st);
    chk("status", {port_ready_in, interrupt_pin_a_in | interrupt_pin_b_in, rdy, cca_result_in,
      c}, st);
  endtask
  task automatic cmd_go(logic [7:0] c, logic [4:0] p, logic [2:0] t);
    int i;
    for (i = 0; i < 300 && controller_ready_flag_out !== 1'b1; i++) @(posedge clk_sys_in);
    if (i == 300) begin
      mismatches++;
      close_out();
    end
    exp_q.push_back({p, t, 14'h0000});
    u_host.frame({c, 8'hff}, 8, st);
  endtask
  task automatic done();
    @(posedge clk_sys_in) rc_done_in <= 1'b1;
    @(posedge clk_sys_in) rc_done_in <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h9265_dd8c));
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    poll(4'h0, 1'b1);
    // every transition; a refused strobe while busy; old code kept until done
    for (int i = 0; i < 6; i++) begin
      cmd_go(8'(8'hb1 + i), 5'h10, tgt[i]);
      u_host.frame(16'hb7ff, 8, st);
      poll(i ? 4'(tgt[i-1]) : 4'h0, 1'b0);
      done();
      poll(4'(tgt[i]), 1'b1);
    end
    cmd_go(8'hb7, 5'h08, 3'h0);
    done();
    cmd_go(8'hc7, 5'h04, 3'h0);
    cmd_go(8'hc8, 5'h02, 3'h0);
    poll(4'h0, 1'b1);
    u_host.frame(16'h00ff, 8, st);
    exp_q.push_back({5'h10, 3'h1, 14'h0000});
    u_host.frame(16'hffb2, 16, st);
    done();
    u_host.frame(16'h1000, 8, st);
    cmd_go(8'hb4, 5'h10, 3'h4);
    port_ready_in <= 1'b1;
    // memory launches while the controller is busy
    for (int k = 1; k < 8; k++) begin
      tv = 8'($urandom);
      rv = 8'($urandom);
      @(posedge clk_sys_in);
      tx_base_in <= tv;
      rx_base_in <= rv;
      cmd = mem_tab[k-1] | ((k > 2 && k < 7) ? 8'($urandom_range(5)) : 8'h00);
      a = k == 1 ? {3'h0, tv} : k == 2 ? {3'h0, rv} : k == 7 ? 11'h000 : {cmd[2:0], 8'h00};
      exp_q.push_back({5'h01, 3'h0, 3'(k), a});
      u_host.frame({cmd, 8'($urandom)}, 9, st);
    end
    done();
    for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge clk_sys_in);
    if (exp_q.size() > 0) mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
